/* File: verilog/otoc_pkg.sv */
// Package for the output test override block: register map, field layout, timing.
// Assumes a 200 MHz core clock and a 32-bit APB register bus.
package otoc_pkg;
    localparam int CLK_MHZ = 200;
    localparam int NUM_GROUPS = 2;
    localparam int OUTS_PER_GROUP = 8;
    localparam int NUM_OUTS = 16;
    localparam int NUM_AIO = 4;
    localparam int AW = 8;
    // Supervision drop time in milliseconds, and its cycle count
    localparam int SUP_DROP_MS = 5000;
    localparam int SUP_DROP_CYC = SUP_DROP_MS * 1000 * CLK_MHZ;
    localparam logic [31:0] TICK_1MS_CYC = 32'(1000 * CLK_MHZ);
    // Register byte offsets
    localparam logic [AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [AW-1:0] OFF_DISARM = 8'h04;
    localparam logic [AW-1:0] OFF_FSINGLE = 8'h08;
    localparam logic [AW-1:0] OFF_FSVAL = 8'h0C;
    localparam logic [AW-1:0] OFF_FGROUP = 8'h10;
    localparam logic [AW-1:0] OFF_TIMEOUT = 8'h14;
    localparam logic [AW-1:0] OFF_CMD = 8'h18;
    localparam logic [AW-1:0] OFF_AFORCE = 8'h1C;
    localparam logic [AW-1:0] OFF_STATUS = 8'h20;
    localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h24;
    localparam logic [AW-1:0] OFF_IRQ_CLR = 8'h28;
    localparam logic [AW-1:0] OFF_IRQ_EN = 8'h2C;
    localparam logic [AW-1:0] OFF_AOVAL = 8'h30;
    // CTRL fields
    localparam int CTRL_DISARM_EN = 0;
    localparam int CTRL_DIS_PERM = 1;
    localparam int CTRL_FRC_PERM = 2;
    localparam int CTRL_ANA_PERM = 3;
    // CMD fields (write one pulses)
    localparam int CMD_DISARM = 0;
    localparam int CMD_UNDISARM = 1;
    localparam int CMD_FORCE = 2;
    localparam int CMD_UNFORCE = 3;
    localparam int CMD_TRIP = 4;
    localparam int CMD_SUP_DROP = 5;
    localparam int CMD_ANA_ON = 6;
    localparam int CMD_ANA_OFF = 7;
    // Interrupt event bits
    localparam int EV_DIS_END = 0;
    localparam int EV_FRC_END = 1;
    localparam int EV_ANA_END = 2;
    localparam int EV_SUP_END = 3;
    localparam int EV_PHASE = 4;
    localparam int NUM_EV = 5;
    localparam logic [31:0] RST_TIMEOUT_MS = 32'h0000_03E8;
endpackage

/* File: verilog/otoc_sync.sv */
// Three-stage synchroniser for one pin level; change accepted when stages 2 and 3 agree.
// Assumes an asynchronous active-high reset on the core clock.
`timescale 1ns/1ps
module otoc_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule

/* File: verilog/otoc_timer.sv */
// Override timer: set by a start pulse, ends by stop, or by a millisecond count unless permanent.
// Assumes a one-cycle millisecond tick enable from the core clock.
`timescale 1ns/1ps
module otoc_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire logic stop,
    input wire logic perm,
    input wire logic [31:0] limit,
    output logic active,
    output logic expired
);
    logic [31:0] count;
    wire logic done = active && !perm && tick && (count + 32'h0000_0001 >= limit);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active <= 1'b0;
            count <= 32'h0000_0000;
            expired <= 1'b0;
        end else begin
            expired <= done;
            if (start) begin
                active <= 1'b1;
                count <= 32'h0000_0000;
            end else if (stop || done) begin
                active <= 1'b0;
            end else if (active && tick) begin
                count <= count + 32'h0000_0001;
            end
        end
    end
endmodule

/* File: verilog/otoc_top.sv */
// Service and test override control: disarm, force, trip, supervision drop, analog force.
// Assumes an APB master on CORE_CLK; pin-level status inputs arrive asynchronously.
//
// Function
// - Flag when measured phase rotation differs from configured rotation.
// - Timed disarm suppresses the outputs selected in DISARM only while its timer runs.
// - Permanent disarm holds until explicitly withdrawn.
// - Zone interlock output and supervision contact are never disarmed.
// - Disarm needs unlatched, no hold timer, disarm enabled, disarm command applied.
// - Timed force holds while timer runs; permanent until removed.
// - Group force wins over single-output force.
// - Disarmed outputs ignore force commands.
// - Force applies only when not disarmed and command hits output or group.
// - Manual trip request asserts trip command like a protection trip.
// - Forced drop releases supervision contact for five seconds then restores.
// - Forced supervision drop logs no supervision message.
// - Forced temperatures held by timer or permanently, then live again.
// - Temperature view is live, frozen while forced, live again after.
// - Forced analog output held by timer or permanently, then assigned value.
// - Analog output view shows assigned value, frozen while forced.
// - Forced analog input replaces measurement while timer runs or permanently.
// - After analog input force ends, measured value is reported again.
`timescale 1ns/1ps
module otoc_top #(
    parameter int SUP_DROP_CYCLES = otoc_pkg::SUP_DROP_CYC
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [15:0] RELAY_REQ,
    input wire logic [15:0] RELAY_LATCHED,
    input wire logic [15:0] RELAY_HOLD_RUN,
    input wire logic ZONE_INTERLOCK_REQ,
    input wire logic SUPERVISION_OK,
    input wire logic PROT_TRIP,
    input wire logic PHASE_ROT_MEAS,
    input wire logic PHASE_ROT_CFG,
    input wire logic [63:0] TEMP_LIVE,
    input wire logic [63:0] AOUT_ASSIGNED,
    input wire logic [63:0] AIN_MEAS,
    output logic [15:0] RELAY_OUT,
    output logic ZONE_INTERLOCK_OUT,
    output logic SELF_SUPERVISION_CONTACT,
    output logic SUPERVISION_MSG_LOG,
    output logic TRIP_CMD,
    output logic PHASE_MISMATCH,
    output logic [63:0] TEMP_OUT,
    output logic [63:0] AOUT_OUT,
    output logic [63:0] AIN_OUT,
    output logic IRQ
);
    // Registers
    logic [31:0] ctrl;
    logic [31:0] disarm_sel;
    logic [31:0] fsingle_sel;
    logic [31:0] fsingle_val;
    logic [31:0] fgroup;
    logic [31:0] timeout_ms;
    logic [31:0] afrc_val;
    logic [31:0] irq_en;
    logic [otoc_pkg::NUM_EV-1:0] irq_stat;
    logic [31:0] tick_cnt;
    logic tick;
    logic trip_req;
    logic [31:0] sup_cnt;
    logic sup_drop;
    logic [63:0] ana_frozen_t;
    logic [63:0] ana_frozen_ao;
    logic [63:0] ana_frozen_ai;

    // APB decode
    wire logic acc = PSEL && PENABLE;
    wire logic wr = acc && PWRITE;
    // A write lands only at the edge that completes the access
    wire logic take = wr && PREADY;
    wire logic a_ctrl = PADDR == otoc_pkg::OFF_CTRL;
    wire logic a_dis = PADDR == otoc_pkg::OFF_DISARM;
    wire logic a_fs = PADDR == otoc_pkg::OFF_FSINGLE;
    wire logic a_fv = PADDR == otoc_pkg::OFF_FSVAL;
    wire logic a_fg = PADDR == otoc_pkg::OFF_FGROUP;
    wire logic a_to = PADDR == otoc_pkg::OFF_TIMEOUT;
    wire logic a_cmd = PADDR == otoc_pkg::OFF_CMD;
    wire logic a_af = PADDR == otoc_pkg::OFF_AFORCE;
    wire logic a_st = PADDR == otoc_pkg::OFF_STATUS;
    wire logic a_is = PADDR == otoc_pkg::OFF_IRQ_STAT;
    wire logic a_ic = PADDR == otoc_pkg::OFF_IRQ_CLR;
    wire logic a_ie = PADDR == otoc_pkg::OFF_IRQ_EN;
    wire logic a_ao = PADDR == otoc_pkg::OFF_AOVAL;
    // Any offset outside this list is answered with PSLVERR
    wire logic mapped = a_ctrl | a_dis | a_fs | a_fv | a_fg | a_to | a_cmd | a_af
        | a_st | a_is | a_ic | a_ie | a_ao;
    wire logic [7:0] cmd = (take && a_cmd) ? PWDATA[7:0] : 8'h00;
    wire logic [otoc_pkg::NUM_EV-1:0] irq_clr =
        (take && a_ic) ? PWDATA[otoc_pkg::NUM_EV-1:0] : 5'h00;

    // Pin inputs from the field side
    logic [15:0] latched_s;
    logic [15:0] hold_s;
    logic sup_bad_s;
    logic rot_meas_s;
    logic rot_cfg_s;

    // Latch and hold-timer states come from the field side, so they are synchronised
    for (genvar i = 0; i < otoc_pkg::NUM_OUTS; i++) begin : g_sync
        otoc_sync u_lat (
            .clk(CORE_CLK),
            .rst(RST),
            .din(RELAY_LATCHED[i]),
            .dout(latched_s[i])
        );
        otoc_sync u_hold (
            .clk(CORE_CLK),
            .rst(RST),
            .din(RELAY_HOLD_RUN[i]),
            .dout(hold_s[i])
        );
    end
    // Synchronised as a fault level, so the reset value means healthy and logs nothing
    otoc_sync u_sok (
        .clk(CORE_CLK),
        .rst(RST),
        .din(!SUPERVISION_OK),
        .dout(sup_bad_s)
    );
    otoc_sync u_rm (
        .clk(CORE_CLK),
        .rst(RST),
        .din(PHASE_ROT_MEAS),
        .dout(rot_meas_s)
    );
    otoc_sync u_rc (
        .clk(CORE_CLK),
        .rst(RST),
        .din(PHASE_ROT_CFG),
        .dout(rot_cfg_s)
    );

    // Override timers: disarm, relay force, analog force
    logic dis_act;
    logic dis_exp;
    logic frc_act;
    logic frc_exp;
    logic ana_act;
    logic ana_exp;

    // Disarm timer; permanent mode ignores the count
    otoc_timer u_tdis (
        .clk(CORE_CLK),
        .rst(RST),
        .tick(tick),
        .start(cmd[otoc_pkg::CMD_DISARM]),
        .stop(cmd[otoc_pkg::CMD_UNDISARM]),
        .perm(ctrl[otoc_pkg::CTRL_DIS_PERM]),
        .limit(timeout_ms),
        .active(dis_act),
        .expired(dis_exp)
    );
    // Relay force timer, shared by single and group force
    otoc_timer u_tfrc (
        .clk(CORE_CLK),
        .rst(RST),
        .tick(tick),
        .start(cmd[otoc_pkg::CMD_FORCE]),
        .stop(cmd[otoc_pkg::CMD_UNFORCE]),
        .perm(ctrl[otoc_pkg::CTRL_FRC_PERM]),
        .limit(timeout_ms),
        .active(frc_act),
        .expired(frc_exp)
    );
    // Analog force timer, shared by all three views
    otoc_timer u_tana (
        .clk(CORE_CLK),
        .rst(RST),
        .tick(tick),
        .start(cmd[otoc_pkg::CMD_ANA_ON]),
        .stop(cmd[otoc_pkg::CMD_ANA_OFF]),
        .perm(ctrl[otoc_pkg::CTRL_ANA_PERM]),
        .limit(timeout_ms),
        .active(ana_act),
        .expired(ana_exp)
    );

    // Relay output path
    wire logic [15:0] dis_sel = disarm_sel[15:0];
    wire logic [15:0] disarmed = {16{dis_act && ctrl[otoc_pkg::CTRL_DISARM_EN]}} & dis_sel
        & ~latched_s & ~hold_s;
    wire logic [15:0] grp_on = {{8{fgroup[1]}}, {8{fgroup[0]}}};
    wire logic [15:0] grp_val = {{8{fgroup[17]}}, {8{fgroup[16]}}};
    // Group force wins where both apply
    wire logic [15:0] frc_val = (grp_on & grp_val) | (~grp_on & fsingle_val[15:0]);
    wire logic [15:0] frc_hit = {16{frc_act}} & (grp_on | fsingle_sel[15:0]) & ~disarmed;
    wire logic [15:0] next_relay = (frc_hit & frc_val) | (~frc_hit & ~disarmed & RELAY_REQ);

    // Status and interrupt events
    wire logic [otoc_pkg::NUM_EV-1:0] ev;
    assign ev[otoc_pkg::EV_DIS_END] = dis_exp;
    assign ev[otoc_pkg::EV_FRC_END] = frc_exp;
    assign ev[otoc_pkg::EV_ANA_END] = ana_exp;
    assign ev[otoc_pkg::EV_SUP_END] = sup_drop && (sup_cnt == 32'h0000_0001);
    // Phase event fires on the rising edge of the mismatch only
    assign ev[otoc_pkg::EV_PHASE] = (rot_meas_s != rot_cfg_s) && !PHASE_MISMATCH;
    // Status bits: IRQ, disarm, force, phase, trip pulse, drop, analog
    wire logic [31:0] status = {25'h0000000, ana_act, sup_drop, trip_req, PHASE_MISMATCH,
        frc_act, dis_act, IRQ};

    // Unmapped and write-only offsets read as zero
    wire logic [31:0] rmux =
        a_ctrl ? ctrl :
        a_dis ? disarm_sel :
        a_fs ? fsingle_sel :
        a_fv ? fsingle_val :
        a_fg ? fgroup :
        a_to ? timeout_ms :
        a_af ? afrc_val :
        a_st ? status :
        a_is ? {27'h0000000, irq_stat} :
        a_ie ? irq_en :
        a_ao ? {16'h0000, RELAY_OUT} : 32'h0000_0000;

    // Wrap at the last count so one tick period is exactly one millisecond
    wire logic tick_wrap = tick_cnt == otoc_pkg::TICK_1MS_CYC - 32'h0000_0001;

    // Millisecond tick for the override timers
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            tick <= tick_wrap;
            tick_cnt <= tick_wrap ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        end
    end

    // APB slave: zero wait states, error on unmapped address
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ctrl <= 32'h0000_0000;
            disarm_sel <= 32'h0000_0000;
            fsingle_sel <= 32'h0000_0000;
            fsingle_val <= 32'h0000_0000;
            fgroup <= 32'h0000_0000;
            timeout_ms <= otoc_pkg::RST_TIMEOUT_MS;
            afrc_val <= 32'h0000_0000;
            irq_en <= 32'h0000_0000;
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !mapped;
            if (PSEL && !PENABLE) begin
                PRDATA <= PWRITE ? 32'h0000_0000 : rmux;
            end
            if (take) begin
                if (a_ctrl) ctrl <= PWDATA;
                if (a_dis) disarm_sel <= PWDATA;
                if (a_fs) fsingle_sel <= PWDATA;
                if (a_fv) fsingle_val <= PWDATA;
                if (a_fg) fgroup <= PWDATA;
                if (a_to) timeout_ms <= PWDATA;
                if (a_af) afrc_val <= PWDATA;
                if (a_ie) irq_en <= PWDATA;
            end
        end
    end

    // Sticky events; a new event wins over a same-cycle clear
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            irq_stat <= 5'h00;
            IRQ <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | ev;
            IRQ <= |(irq_stat & irq_en[otoc_pkg::NUM_EV-1:0]);
        end
    end

    // Relays, trip and supervision contact
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RELAY_OUT <= 16'h0000;
            ZONE_INTERLOCK_OUT <= 1'b0;
            trip_req <= 1'b0;
            TRIP_CMD <= 1'b0;
            sup_cnt <= 32'h0000_0000;
            sup_drop <= 1'b0;
            SELF_SUPERVISION_CONTACT <= 1'b0;
            SUPERVISION_MSG_LOG <= 1'b0;
            PHASE_MISMATCH <= 1'b0;
        end else begin
            RELAY_OUT <= next_relay;
            ZONE_INTERLOCK_OUT <= ZONE_INTERLOCK_REQ;
            // Trip request is a one-cycle pulse merged with the protection trip
            trip_req <= cmd[otoc_pkg::CMD_TRIP];
            TRIP_CMD <= PROT_TRIP | trip_req;
            if (cmd[otoc_pkg::CMD_SUP_DROP]) begin
                sup_drop <= 1'b1;
                sup_cnt <= 32'(SUP_DROP_CYCLES);
            end else if (sup_drop) begin
                sup_cnt <= sup_cnt - 32'h0000_0001;
                sup_drop <= sup_cnt != 32'h0000_0001;
            end
            // Contact is never disarmed, only dropped by the test or by a real fault
            SELF_SUPERVISION_CONTACT <= !sup_bad_s && !sup_drop;
            // Only a real supervision failure is logged, not a test drop
            SUPERVISION_MSG_LOG <= sup_bad_s;
            PHASE_MISMATCH <= rot_meas_s != rot_cfg_s;
        end
    end

    // Analog views: live, frozen at force start, then forced value while active
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ana_frozen_t <= 64'h0000_0000_0000_0000;
            ana_frozen_ao <= 64'h0000_0000_0000_0000;
            ana_frozen_ai <= 64'h0000_0000_0000_0000;
            TEMP_OUT <= 64'h0000_0000_0000_0000;
            AOUT_OUT <= 64'h0000_0000_0000_0000;
            AIN_OUT <= 64'h0000_0000_0000_0000;
        end else begin
            if (cmd[otoc_pkg::CMD_ANA_ON] && !ana_act) begin
                ana_frozen_t <= TEMP_LIVE;
                ana_frozen_ao <= AOUT_ASSIGNED;
                ana_frozen_ai <= AIN_MEAS;
                // A repeated start keeps the first snapshot
            end else if (take && a_af) begin
                // Forced word written into the channel chosen by bits 17:16
                ana_frozen_t[PWDATA[17:16]*16 +: 16] <= PWDATA[15:0];
                ana_frozen_ao[PWDATA[17:16]*16 +: 16] <= PWDATA[15:0];
                ana_frozen_ai[PWDATA[17:16]*16 +: 16] <= PWDATA[15:0];
            end
            TEMP_OUT <= ana_act ? ana_frozen_t : TEMP_LIVE;
            AOUT_OUT <= ana_act ? ana_frozen_ao : AOUT_ASSIGNED;
            AIN_OUT <= ana_act ? ana_frozen_ai : AIN_MEAS;
        end
    end
endmodule

/* File: bench/otoc_apb_host.sv */
// APB master standing in for the operator panel or communication link.
// Assumes one clock shared with the block and one transfer at a time.
`timescale 1ns/1ps
module otoc_apb_host (
    input wire logic clk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show no stale value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

/* File: bench/otoc_chk.sv */
// Checker for the override block: APB answer and pin timing relations.
// Assumes it is bound to otoc_top and sees only its ports.
`timescale 1ns/1ps
module otoc_chk #(
    parameter int SUP_DROP_CYCLES = 100
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input logic [31:0] PRDATA,
    input logic PREADY,
    input logic PSLVERR,
    input wire logic ZONE_INTERLOCK_REQ,
    input logic ZONE_INTERLOCK_OUT,
    input wire logic SUPERVISION_OK,
    input logic SELF_SUPERVISION_CONTACT,
    input logic SUPERVISION_MSG_LOG,
    input logic TRIP_CMD,
    input wire logic PHASE_ROT_MEAS,
    input wire logic PHASE_ROT_CFG,
    input logic PHASE_MISMATCH
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    wire cmd_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == otoc_pkg::OFF_CMD;
    int low_cnt;
    // Counts how long the contact stays dropped
    always_ff @(posedge CORE_CLK or posedge RST)
        if (RST) low_cnt <= 0;
        else low_cnt <= (SELF_SUPERVISION_CONTACT || !SUPERVISION_OK) ? 0 : low_cnt + 1;

    a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access phase");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_slverr_zero: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error answer malformed");
    a_zone_follow: assert property ($past(!RST) |-> ZONE_INTERLOCK_OUT == $past(ZONE_INTERLOCK_REQ))
        else $error("zone output not following request");
    a_trip_cmd: assert property (cmd_wr && PWDATA[otoc_pkg::CMD_TRIP] |-> ##[2:3] TRIP_CMD)
        else $error("trip command missing");
    a_sup_drop: assert property (cmd_wr && PWDATA[otoc_pkg::CMD_SUP_DROP] |-> ##[2:3] !SELF_SUPERVISION_CONTACT)
        else $error("contact did not drop");
    a_drop_length: assert property (low_cnt <= SUP_DROP_CYCLES)
        else $error("contact dropped too long");
    a_sup_silent: assert property (SUPERVISION_OK [*8] |-> !SUPERVISION_MSG_LOG)
        else $error("message logged while healthy");
    a_phase_set: assert property ((PHASE_ROT_MEAS != PHASE_ROT_CFG) [*8] |-> PHASE_MISMATCH)
        else $error("phase mismatch not flagged");
    a_phase_clr: assert property ((PHASE_ROT_MEAS == PHASE_ROT_CFG) [*8] |-> !PHASE_MISMATCH)
        else $error("phase mismatch flagged wrongly");
endmodule

bind otoc_top otoc_chk #(.SUP_DROP_CYCLES(SUP_DROP_CYCLES)) i_otoc_chk (
    .CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .ZONE_INTERLOCK_REQ, .ZONE_INTERLOCK_OUT, .SUPERVISION_OK,
    .SELF_SUPERVISION_CONTACT, .SUPERVISION_MSG_LOG, .TRIP_CMD, .PHASE_ROT_MEAS,
    .PHASE_ROT_CFG, .PHASE_MISMATCH
);

/* File: bench/output_test_override_control_tb.sv */
// Self-checking bench: registers, interrupt, relays, trip, supervision, analog views.
// Assumes otoc_top with a short supervision drop, driven by the APB host model.
`timescale 1ns/1ps
module output_test_override_control_tb;
    localparam int DROP = 100;
    logic clk, rst, pready, pslverr, psel, penable, pwrite, t;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] req, lat, hold, rout;
    logic zreq, sok, ptrip, pmeas, pcfg, zout, scc, slog, trip, pmis, irq;
    logic [63:0] tlive, alive, ilive, tout, aout, iout, t0, a0, i0;
    logic [32:0] rq[$];
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    otoc_top #(.SUP_DROP_CYCLES(DROP)) i_otoc_top (
        .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RELAY_REQ(req), .RELAY_LATCHED(lat), .RELAY_HOLD_RUN(hold),
        .ZONE_INTERLOCK_REQ(zreq), .SUPERVISION_OK(sok), .PROT_TRIP(ptrip),
        .PHASE_ROT_MEAS(pmeas), .PHASE_ROT_CFG(pcfg), .TEMP_LIVE(tlive),
        .AOUT_ASSIGNED(alive), .AIN_MEAS(ilive), .RELAY_OUT(rout), .ZONE_INTERLOCK_OUT(zout),
        .SELF_SUPERVISION_CONTACT(scc), .SUPERVISION_MSG_LOG(slog), .TRIP_CMD(trip),
        .PHASE_MISMATCH(pmis), .TEMP_OUT(tout), .AOUT_OUT(aout), .AIN_OUT(iout), .IRQ(irq)
    );
    otoc_apb_host i_otoc_apb_host (.clk(clk), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_otoc_apb_host.xfer(1'b1, a, d);
    endtask
    // Expected read word is noted first; the watcher below compares it
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        i_otoc_apb_host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic smp(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            wrap_up();
        end
        if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0)
            chk(64'({pslverr, prdata}), 64'(rq.pop_front()));
    end

    initial begin
        void'($urandom(32'h1AE5));
        rst = 1'b1;
        req = 16'h0;
        lat = 16'h0001;
        hold = 16'h0002;
        zreq = 1'b0;
        sok = 1'b1;
        ptrip = 1'b0;
        pmeas = 1'b0;
        pcfg = 1'b0;
        tlive = {$urandom, $urandom};
        alive = {$urandom, $urandom};
        ilive = {$urandom, $urandom};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        smp(8);
        rd(otoc_pkg::OFF_TIMEOUT, {1'b0, otoc_pkg::RST_TIMEOUT_MS});
        rd(8'hFC, 33'h1_0000_0000);
        wr(8'hFC, 32'hFFFF_FFFF);
        rd(otoc_pkg::OFF_CTRL, 33'h0);
        done("registers");
        wr(otoc_pkg::OFF_IRQ_EN, 32'h10);
        @(posedge clk);
        pmeas <= 1'b1;
        smp(10);
        chk(64'({pmis, irq}), 64'h3);
        rd(otoc_pkg::OFF_IRQ_STAT, 33'h10);
        wr(otoc_pkg::OFF_IRQ_EN, 32'h0);
        smp(2);
        chk(64'(irq), 64'h0);
        wr(otoc_pkg::OFF_IRQ_EN, 32'h10);
        wr(otoc_pkg::OFF_IRQ_CLR, 32'h10);
        smp(2);
        chk(64'(irq), 64'h0);
        @(posedge clk);
        pmeas <= 1'b0;
        smp(10);
        chk(64'(pmis), 64'h0);
        done("phase");
        wr(otoc_pkg::OFF_CTRL, 32'h3);
        wr(otoc_pkg::OFF_DISARM, 32'hFF);
        wr(otoc_pkg::OFF_CMD, 32'h1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            req <= 16'($urandom);
            zreq <= 1'($urandom);
            smp(2);
            chk(64'({zout, rout}), 64'({zreq, req & 16'hFF03}));
        end
        wr(otoc_pkg::OFF_CTRL, 32'h7);
        wr(otoc_pkg::OFF_FSINGLE, 32'h210);
        wr(otoc_pkg::OFF_FSVAL, 32'hFFFF);
        wr(otoc_pkg::OFF_FGROUP, 32'h2);
        wr(otoc_pkg::OFF_CMD, 32'h4);
        @(posedge clk);
        req <= 16'hFFFF;
        smp(2);
        chk(64'(rout), 64'h3);
        wr(otoc_pkg::OFF_FGROUP, 32'h0);
        wr(otoc_pkg::OFF_CMD, 32'h4);
        @(posedge clk);
        req <= 16'h0;
        smp(2);
        chk(64'(rout), 64'h200);
        wr(otoc_pkg::OFF_CMD, 32'h2);
        smp(2);
        chk(64'(rout), 64'h210);
        wr(otoc_pkg::OFF_CMD, 32'h8);
        smp(2);
        chk(64'(rout), 64'h0);
        done("relays");
        wr(otoc_pkg::OFF_CMD, 32'h10);
        smp(1);
        t = trip;
        smp(1);
        chk(64'({t, trip}), 64'h2);
        smp(1);
        chk(64'(trip), 64'h0);
        @(posedge clk);
        ptrip <= 1'b1;
        smp(3);
        chk(64'(trip), 64'h1);
        @(posedge clk);
        ptrip <= 1'b0;
        wr(otoc_pkg::OFF_CMD, 32'h20);
        smp(3);
        chk(64'({scc, slog}), 64'h0);
        smp(DROP);
        chk(64'({scc, slog}), 64'h2);
        rd(otoc_pkg::OFF_IRQ_STAT, 33'h08);
        @(posedge clk);
        sok <= 1'b0;
        smp(8);
        chk(64'({scc, slog}), 64'h1);
        @(posedge clk);
        sok <= 1'b1;
        smp(8);
        done("trip and supervision");
        wr(otoc_pkg::OFF_CTRL, 32'h8);
        smp(1);
        chk(tout, tlive);
        chk(aout, alive);
        wr(otoc_pkg::OFF_CMD, 32'h40);
        wr(otoc_pkg::OFF_AFORCE, 32'h2_1234);
        {t0, a0, i0} = {tlive, alive, ilive};
        t0[47:32] = 16'h1234;
        a0[47:32] = 16'h1234;
        i0[47:32] = 16'h1234;
        @(posedge clk);
        tlive <= {$urandom, $urandom};
        alive <= {$urandom, $urandom};
        ilive <= {$urandom, $urandom};
        smp(3);
        chk(tout, t0);
        chk(aout, a0);
        chk(iout, i0);
        wr(otoc_pkg::OFF_CMD, 32'h80);
        smp(2);
        chk(tout, tlive);
        chk(iout, ilive);
        chk(aout, alive);
        done("analog");
        wrap_up();
    end
endmodule
